// >>> rtl/clkbuf_regs.svh
// Constants for the four-output clock buffer control block and its host end.
// Included by the pin state, device and host files; holds definitions only.
`ifndef CLKBUF_REGS_SVH
`define CLKBUF_REGS_SVH

`define PD_LAST_TICK    2'h2
`define ADDR_LOW        8'hd8
`define ADDR_MID        8'hda
`define ADDR_HIGH       8'hde

`define REG_CTL1        7'h00
`define REG_EN1         7'h01
`define REG_EN2         7'h02
`define REG_PINS        7'h03
`define REG_VENDOR      7'h05
`define REG_DEVICE      7'h06
`define REG_COUNT       7'h07
`define REG_OUTPUT_SETTING_REG      7'h08
`define REG_TRIM        7'h4c

`define RST_CTL1_HI     4'h4
`define RST_CTL1_LO     4'h7
`define RST_EN1         8'hff
`define RST_EN2         8'h0f
`define RST_COUNT       8'h09
`define RST_OUTPUT_SETTING_REG      8'h00
`define RST_TRIM        8'h00
// Identification values are arbitrary.
`define VENDOR_ID       8'h5a
`define DEVICE_ID       8'ha5

`define EN1_CH1         5
`define EN1_CH0         2
`define EN2_CH3         2
`define EN2_CH2         0
`define OUTPUT_SETTING_REG_TERM     5
`define OUTPUT_SETTING_REG_DRV      4
`define CMD_BYTE_BIT    7

`define H_PINS          4'h0
`define H_BEAT          4'h4
`define H_STAT          4'h8
`define HP_PIN          0
`define HP_SUP          1
`define HP_REF          2
`define HP_OE           4
`define HP_STRAP        8
`define HB_FIRST        8
`define HB_LAST         9
`define HP_RESET        10'h00f2
`define REF_DIV_LAST    4'h1
`define REF_HOLD        2'h3

`endif

// >>> rtl/clkbuf_pkg.sv
// Types shared by both ends of the clock buffer control link.
// Assumes nothing of its surroundings.
package clkbuf_pkg;
	typedef enum logic [1:0] {STRAP_LOW = 2'h0, STRAP_MID = 2'h1, STRAP_HIGH = 2'h2} strap_t;
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_OPEN  = 5'h02,
		H_BEAT  = 5'h04,
		H_WAIT  = 5'h08,
		H_CLOSE = 5'h10
	} host_state_t;
endpackage

// >>> rtl/clkbuf_link_if.sv
// Link between the clock buffer control device and its host and board pins.
// Assumes one clock for both ends; the testbench joins the modports.
`timescale 1ns/100ps
`default_nettype none
interface clkbuf_link_if;
	logic                 pgpd;
	logic                 supply_ok;
	logic                 ref_tick;
	logic [3:0]           oe_n;
	clkbuf_pkg::strap_t   strap;
	logic                 sel;
	logic                 beat;
	logic [7:0]           wbyte;
	logic                 ack;
	logic [7:0]           rbyte;
	logic                 drive;
	modport dev (input pgpd, supply_ok, ref_tick, oe_n, strap, sel, beat, wbyte, output ack, rbyte, drive);
	modport host (output pgpd, supply_ok, ref_tick, oe_n, strap, sel, beat, wbyte, input ack, rbyte, drive);
endinterface
`default_nettype wire

// >>> rtl/clkbuf_pin_state.sv
// Tracks power good and power-down from the shared pin.
// Assumes the pin, supply flag and reference tick are synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "clkbuf_regs.svh"
module clkbuf_pin_state (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	input  wire logic pin_i,
	input  wire logic supply_ok_i,
	input  wire logic ref_tick_i,
	output logic      power_good_o,
	output logic      powerdown_o,
	output logic      pg_rise_o
);
	logic       pin_q;
	logic [1:0] ticks;
	logic       pin_rise;

	assign pin_rise  = pin_i & ~pin_q;
	assign pg_rise_o = pin_rise & ~power_good_o;

	always_ff @(posedge sys_clk_i)
	begin
		pin_q <= srst_i ? 1'b0 : pin_i;
	end

	// Only supply loss or power-on reset clears it; later pin edges never re-evaluate it.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !supply_ok_i)
			power_good_o <= 1'b0;
		else if (pin_rise)
			power_good_o <= 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !supply_ok_i || !power_good_o)
		begin
			powerdown_o <= 1'b0;
			ticks       <= 2'h0;
		end
		else if (!pin_i)
		begin
			if (!powerdown_o && ref_tick_i)
			begin
				if (ticks == `PD_LAST_TICK)
					powerdown_o <= 1'b1;
				ticks <= ticks + 2'h1;
			end
		end
		else
		begin
			ticks <= 2'h0;
			if (powerdown_o && ref_tick_i)
				powerdown_o <= 1'b0;
		end
	end
endmodule // clkbuf_pin_state
`default_nettype wire

// >>> rtl/clkbuf_dev.sv
// Control logic of the four-output clock buffer: pin states, bus registers, output gating.
// Assumes link inputs are synchronous to sys_clk_i and srst_i models power-on.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "clkbuf_regs.svh"
module clkbuf_dev (
	input  wire logic     sys_clk_i,
	input  wire logic     srst_i,
	clkbuf_link_if.dev    link,
	output logic [3:0]    ch_run_o,
	output logic [3:0]    ch_hiz_o,
	output logic          term_100_o,
	output logic [7:0]    slew_trim_o,
	output logic          power_good_o,
	output logic          powerdown_o
);
	logic       pg;
	logic       pd;
	logic       pg_rise;
	logic       active;
	logic [7:0] my_addr;
	logic [3:0] ctl1_lo;
	logic [7:0] en1;
	logic [7:0] en2;
	logic [7:0] count;
	logic [7:0] output_setting_reg;
	logic [7:0] trim;
	logic [1:0] beat_no;
	logic       hit;
	logic       rd_frame;
	logic       block;
	logic [6:0] ptr;
	logic       take;
	logic       accept;
	logic       wr_en;
	logic       rd_en;
	logic       step;
	logic [3:0] ch_en;
	logic       up;

	clkbuf_pin_state u_pin_state (
		.sys_clk_i   (sys_clk_i),
		.srst_i      (srst_i),
		.pin_i       (link.pgpd),
		.supply_ok_i (link.supply_ok),
		.ref_tick_i  (link.ref_tick),
		.power_good_o(pg),
		.powerdown_o (pd),
		.pg_rise_o   (pg_rise)
	);

	assign power_good_o = pg;
	assign powerdown_o  = pd;

	function automatic logic [7:0] reg_read(input logic [6:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			`REG_CTL1:   v = {`RST_CTL1_HI, ctl1_lo};
			`REG_EN1:    v = en1;
			`REG_EN2:    v = en2;
			`REG_PINS:   v = {4'h0, link.oe_n};
			`REG_VENDOR: v = `VENDOR_ID;
			`REG_DEVICE: v = `DEVICE_ID;
			`REG_COUNT:  v = count;
			`REG_OUTPUT_SETTING_REG: v = output_setting_reg;
			`REG_TRIM:   v = trim;
			default:     v = 8'h00;
		endcase
		return v;
	endfunction

	// The bus is floated whenever the pin is low; registers keep their values.
	assign active     = pg & link.pgpd;
	assign link.drive = active;
	assign take       = link.sel & link.beat & active;

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			my_addr <= `ADDR_LOW;
		else if (pg_rise)
		begin
			case (link.strap)
				clkbuf_pkg::STRAP_MID:  my_addr <= `ADDR_MID;
				clkbuf_pkg::STRAP_HIGH: my_addr <= `ADDR_HIGH;
				default:                my_addr <= `ADDR_LOW;
			endcase
		end
	end

	// Beat 0 is the slave address, beat 1 the command or first read byte.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !link.sel)
		begin
			beat_no  <= 2'h0;
			hit      <= 1'b0;
			rd_frame <= 1'b0;
		end
		else if (take)
		begin
			if (beat_no != 2'h3)
				beat_no <= beat_no + 2'h1;
			if (beat_no == 2'h0)
			begin
				hit      <= link.wbyte[7:1] == my_addr[7:1];
				rd_frame <= link.wbyte[0];
			end
		end
	end

	// Block frames carry a count byte before data; byte frames carry one data byte.
	assign accept = hit & ((beat_no == 2'h1) | block | ((beat_no == 2'h2) & ~rd_frame));
	assign wr_en  = take & hit & ~rd_frame & (block ? (beat_no == 2'h3) : (beat_no == 2'h2));
	assign rd_en  = take & hit & rd_frame & (block ? (beat_no != 2'h0) : (beat_no == 2'h1));
	assign step   = block & ((wr_en) | (rd_en & (beat_no != 2'h1)));

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			block <= 1'b0;
			ptr   <= 7'h00;
		end
		else if (take & hit & ~rd_frame & (beat_no == 2'h1))
		begin
			block <= ~link.wbyte[`CMD_BYTE_BIT];
			ptr   <= link.wbyte[6:0];
		end
		else if (step)
			ptr <= ptr + 7'h01;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			link.ack <= 1'b0;
		else
			link.ack <= take & ((beat_no == 2'h0) ? (link.wbyte[7:1] == my_addr[7:1]) : accept);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			link.rbyte <= 8'h00;
		else if (rd_en)
			link.rbyte <= (block && beat_no == 2'h1) ? count : reg_read(ptr);
	end

	// Pin state never resets these registers; only power-on does.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ctl1_lo <= `RST_CTL1_LO;
			en1     <= `RST_EN1;
			en2     <= `RST_EN2;
			count   <= `RST_COUNT;
			output_setting_reg  <= `RST_OUTPUT_SETTING_REG;
			trim    <= `RST_TRIM;
		end
		else if (wr_en)
		begin
			case (ptr)
				`REG_CTL1:   ctl1_lo <= link.wbyte[3:0];
				`REG_EN1:    en1     <= link.wbyte;
				`REG_EN2:    en2     <= link.wbyte;
				`REG_COUNT:  count   <= link.wbyte;
				`REG_OUTPUT_SETTING_REG: output_setting_reg  <= link.wbyte;
				`REG_TRIM:   trim    <= link.wbyte;
				default:     ;
			endcase
		end
	end

	assign ch_en = {en2[`EN2_CH3], en2[`EN2_CH2], en1[`EN1_CH1], en1[`EN1_CH0]};
	assign up    = pg & ~pd;

	// The enable pins act without any clocked stage in their path.
	assign ch_run_o = ch_en & ~link.oe_n & {4{up}};
	assign ch_hiz_o = ~ch_run_o & {4{pg & output_setting_reg[`OUTPUT_SETTING_REG_DRV]}};

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			term_100_o  <= 1'b0;
			slew_trim_o <= `RST_TRIM;
		end
		else
		begin
			term_100_o  <= output_setting_reg[`OUTPUT_SETTING_REG_TERM];
			slew_trim_o <= trim;
		end
	end
endmodule // clkbuf_dev
`default_nettype wire

// >>> rtl/clkbuf_host.sv
// Host end: board pin drivers, reference clock ticks and a byte-beat bus master.
// Assumes a plain register port from software, synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "clkbuf_regs.svh"
module clkbuf_host (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	clkbuf_link_if.host      link
);
	clkbuf_pkg::host_state_t state;
	logic [9:0] pins;
	logic [9:0] beat_reg;
	logic       acked;
	logic [7:0] rx;
	logic [3:0] div;
	logic [1:0] hold;
	logic       ref_run;
	logic       pin_q;

	assign ref_run       = pins[`HP_REF] | (hold != 2'h0);
	assign link.ref_tick = ref_run & (div == `REF_DIV_LAST);
	assign link.supply_ok = pins[`HP_SUP];
	assign link.oe_n     = pins[`HP_OE +: 4];
	assign link.strap    = clkbuf_pkg::strap_t'(pins[`HP_STRAP +: 2]);
	assign link.pgpd     = pin_q;
	assign link.beat     = state == clkbuf_pkg::H_BEAT;
	assign link.wbyte    = beat_reg[7:0];

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			pins <= `HP_RESET;
		else if (wr_i && addr_i == `H_PINS)
			pins <= wdata_i[9:0];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !ref_run || div == `REF_DIV_LAST)
			div <= 4'h0;
		else
			div <= div + 4'h1;
	end

	// The pin rises only with the reference running, and the reference outlives a fall.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !pins[`HP_SUP] || !pins[`HP_PIN])
			pin_q <= 1'b0;
		else if (ref_run)
			pin_q <= 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			hold <= 2'h0;
		else if (pin_q && (!pins[`HP_SUP] || !pins[`HP_PIN]))
			hold <= `REF_HOLD;
		else if (link.ref_tick && hold != 2'h0)
			hold <= hold - 2'h1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state    <= clkbuf_pkg::H_IDLE;
			beat_reg <= 10'h000;
			link.sel <= 1'b0;
			acked    <= 1'b0;
			rx       <= 8'h00;
		end
		else
		begin
			case (state)
				clkbuf_pkg::H_IDLE:
					if (wr_i && addr_i == `H_BEAT)
					begin
						beat_reg <= wdata_i[9:0];
						state    <= link.sel ? clkbuf_pkg::H_BEAT : clkbuf_pkg::H_OPEN;
					end
				clkbuf_pkg::H_OPEN:
				begin
					link.sel <= 1'b1;
					state    <= clkbuf_pkg::H_BEAT;
				end
				clkbuf_pkg::H_BEAT:
					state <= clkbuf_pkg::H_WAIT;
				clkbuf_pkg::H_WAIT:
				begin
					acked <= link.ack & link.drive;
					if (link.ack && link.drive)
						rx <= link.rbyte;
					state <= beat_reg[`HB_LAST] ? clkbuf_pkg::H_CLOSE : clkbuf_pkg::H_IDLE;
				end
				clkbuf_pkg::H_CLOSE:
				begin
					link.sel <= 1'b0;
					state    <= clkbuf_pkg::H_IDLE;
				end
				default:
					state <= clkbuf_pkg::H_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i)
		begin
			case (addr_i)
				`H_PINS: rdata_o <= {22'h000000, pins};
				`H_BEAT: rdata_o <= {22'h000000, beat_reg};
				`H_STAT: rdata_o <= {14'h0000, ref_run, pin_q, rx, 6'h00, acked, state != clkbuf_pkg::H_IDLE};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end
		else
			rdata_o <= 32'h0000_0000;
	end
endmodule // clkbuf_host
`default_nettype wire

// >>> dv/clkbuf_link_properties.sv
// Concurrent checks on the link between the clock buffer host and device ends.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/100ps
`default_nettype none
module clkbuf_link_properties (
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic       pgpd,
	input  wire logic       supply_ok,
	input  wire logic [3:0] oe_n,
	input  wire logic       sel,
	input  wire logic       beat,
	input  wire logic       ack,
	input  wire logic       drive,
	input  wire logic       power_good_o,
	input  wire logic       powerdown_o,
	input  wire logic [3:0] ch_run_o,
	input  wire logic [3:0] ch_hiz_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_beat_taken;
		sel && beat && drive;
	endsequence
	sequence s_beat_dropped;
		sel && beat && !drive;
	endsequence
	chk_run_gate: assert property ((|ch_run_o) |-> power_good_o && !powerdown_o && !(|(ch_run_o & oe_n)))
		else $error("channel runs while gated off");
	chk_prelatch_low: assert property (!power_good_o |-> ch_run_o == 4'h0 && ch_hiz_o == 4'h0)
		else $error("outputs not low before power good");
	chk_hiz_excl: assert property ((ch_run_o & ch_hiz_o) == 4'h0)
		else $error("channel runs and floats at once");
	chk_pg_set: assert property ($rose(power_good_o) |-> $past(pgpd) && $past(supply_ok))
		else $error("power good set without pin rise");
	chk_pg_hold: assert property (power_good_o && supply_ok |=> power_good_o)
		else $error("power good lost with supply present");
	chk_pd_enter: assert property ($rose(powerdown_o) |-> power_good_o && !$past(pgpd))
		else $error("power-down entered without pin low");
	chk_pd_leave: assert property (powerdown_o && pgpd |-> ##[1:6] !powerdown_o)
		else $error("power-down not left after pin high");
	chk_drive_gate: assert property (drive |-> power_good_o && pgpd)
		else $error("bus driven while pin low");
	chk_beat_dropped: assert property (s_beat_dropped |=> !ack)
		else $error("beat answered while bus released");
	chk_ack_cause: assert property (ack |-> $past(sel && beat && drive))
		else $error("answer without a taken beat");
	cov_beat_taken: cover property (s_beat_taken ##1 ack);
endmodule // clkbuf_link_properties
`default_nettype wire

// >>> dv/test_clock_buffer_output_control.sv
// Testbench joining host and device ends; drives the host register port.
// Assumes the design files under rtl and the checker beside it.
`timescale 1ns/100ps
`default_nettype none
module test_clock_buffer_output_control;
	logic        sys_clk_i;
	logic        srst_i;
	logic [3:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [3:0]  ch_run;
	logic [3:0]  ch_hiz;
	logic        term_100;
	logic [7:0]  slew_trim;
	logic        power_good;
	logic        powerdown;
	logic [31:0] st;
	int          n_errors;
	int          check_count;
	int          cycles = 0;
	clkbuf_link_if link ();
	clkbuf_host u_clkbuf_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
	clkbuf_dev u_clkbuf_dev (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link), .ch_run_o(ch_run),
		.ch_hiz_o(ch_hiz), .term_100_o(term_100), .slew_trim_o(slew_trim), .power_good_o(power_good),
		.powerdown_o(powerdown));
	clkbuf_link_properties u_clkbuf_link_properties (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.pgpd(link.pgpd), .supply_ok(link.supply_ok), .oe_n(link.oe_n), .sel(link.sel), .beat(link.beat),
		.ack(link.ack), .drive(link.drive), .power_good_o(power_good), .powerdown_o(powerdown),
		.ch_run_o(ch_run), .ch_hiz_o(ch_hiz));
	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// One byte beat on the link, then poll the busy flag under a bound.
	task automatic send(input logic [9:0] b);
		wr_reg(4'h4, {22'h0, b});
		repeat (3) @(posedge sys_clk_i);
		for (int k = 0; k < 20; k++)
		begin
			rd_reg(4'h8, st);
			if (st[0] === 1'b0)
				break;
		end
	endtask
	task automatic wait_pins(input logic [9:0] p, input int n);
		wr_reg(4'h0, {22'h0, p});
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_errors++;
			finish_test();
		end
	end
	initial
	begin
		srst_i = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1;
		cmp("power_good", 32'h0, power_good);
		cmp("ch_hiz", 32'h0, ch_hiz);
		wait_pins(10'h0f6, 4);
		wait_pins(10'h0f7, 8);
		cmp("power_good", 32'h1, power_good);
		cmp("ch_run", 32'h0, ch_run);
		wait_pins(10'h0e7, 2);
		cmp("ch_run", 32'h1, ch_run);
		wait_pins(10'h007, 2);
		cmp("ch_run", 32'hf, ch_run);
		$display("test pins done");
		send(10'h1d8);
		send(10'h081);
		send(10'h220);
		cmp("acked", 32'h1, st[1]);
		cmp("ch_run", 32'he, ch_run);
		send(10'h1d8);
		send(10'h088);
		send(10'h230);
		cmp("term_100", 32'h1, term_100);
		cmp("ch_hiz", 32'h1, ch_hiz);
		send(10'h1d9);
		send(10'h200);
		cmp("rx", 32'h30, st[15:8]);
		send(10'h1d8);
		send(10'h04c);
		send(10'h001);
		send(10'h215);
		cmp("slew_trim", 32'h15, slew_trim);
		// A block command with no data only moves the pointer; the block read then returns count first.
		send(10'h1d8);
		send(10'h201);
		send(10'h1d9);
		send(10'h000);
		cmp("rx", 32'h09, st[15:8]);
		send(10'h000);
		cmp("rx", 32'h20, st[15:8]);
		send(10'h200);
		cmp("rx", 32'h0f, st[15:8]);
		send(10'h3da);
		cmp("acked", 32'h0, st[1]);
		$display("test bus done");
		wait_pins(10'h006, 20);
		cmp("powerdown", 32'h1, powerdown);
		cmp("power_good", 32'h1, power_good);
		cmp("ch_hiz", 32'hf, ch_hiz);
		send(10'h3d8);
		cmp("acked", 32'h0, st[1]);
		wait_pins(10'h007, 10);
		cmp("powerdown", 32'h0, powerdown);
		cmp("ch_run", 32'he, ch_run);
		cmp("slew_trim", 32'h15, slew_trim);
		// With the reference switched off, only the host's hold after the fall can finish power-down entry.
		wait_pins(10'h002, 12);
		cmp("powerdown", 32'h1, powerdown);
		wait_pins(10'h003, 8);
		rd_reg(4'h8, st);
		cmp("pin_level", 32'h0, st[16]);
		cmp("powerdown", 32'h1, powerdown);
		wait_pins(10'h005, 6);
		cmp("power_good", 32'h0, power_good);
		$display("test power done");
		finish_test();
	end
endmodule // test_clock_buffer_output_control
`default_nettype wire
